// ### spfs_cfg.svh
`ifndef SPFS_CFG_SVH
`define SPFS_CFG_SVH
`define SPFS_OFF_GPIO_EN 8'h00
`define SPFS_OFF_GPIO_DIR 8'h04
`define SPFS_OFF_GPIO_OUT 8'h08
`define SPFS_OFF_GPIO_IN 8'h0C
`define SPFS_OFF_PERIPHERAL_CONFIG_REG 8'h10
`define SPFS_OFF_A1DIR 8'h14
`define SPFS_OFF_STATUS 8'h18
`define SPFS_GPIO_MASK 16'hFE06
`define SPFS_GPIO_EN_RST 16'h0000
`define SPFS_GPIO_DIR_RST 16'h0000
`define SPFS_GPIO_OUT_RST 16'h0000
`define SPFS_AFC_RST 2'h0
`define SPFS_AFC_NONE 2'h3
`define SPFS_A1DIR_RST 18'h00000
`define SPFS_A1_FS_BIT 16
`define SPFS_A1_CLK_BIT 17
`define SPFS_BIT_WIDTH 10
`define SPFS_BIT_HOSTDIS 8
`define SPFS_GPIO_CLK_LSB 1
`define SPFS_GPIO_HI_LSB 9
`define SPFS_STRAP_DIS_RST 1'b0
`define SPFS_STRAP_HD5_RST 1'b1
`define SPFS_QUARTER_HALF 3'h2
`define SPFS_SIXTH_HALF 3'h3
`define SPFS_RESP_OKAY 2'h0
`define SPFS_RESP_SLVERR 2'h2
`endif

// ### spfs_pkg.sv
package spfs_pkg;
    typedef enum logic [3:0]
    {
        SPFS_OWN_NONE = 4'h1,
        SPFS_OWN_PRIMARY = 4'h2,
        SPFS_OWN_AUDIO = 4'h4,
        SPFS_OWN_GPIO = 4'h8
    } spfs_owner_t;
    typedef enum logic [1:0]
    {
        SPFS_ST_WAIT = 2'h1,
        SPFS_ST_HELD = 2'h2
    } spfs_strap_st_t;
    typedef struct packed
    {
        logic host_dis;
        logic hd5_wide;
    } spfs_strap_t;
    typedef struct packed
    {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } spfs_wr_t;
endpackage : spfs_pkg

// ### spfs_pad_cell.sv
`timescale 1ns/1ps
`default_nettype none
module spfs_pad_cell #(parameter int W = 1)
(
    input wire spfs_pkg::spfs_owner_t sel, // Current owner of these pads
    input wire logic [W-1:0] prim_out, // Primary function drive
    input wire logic [W-1:0] prim_oe, // Primary function enable
    input wire logic [W-1:0] audio_out, // Audio port drive
    input wire logic [W-1:0] audio_oe, // Audio port enable
    input wire logic [W-1:0] gpio_out, // GPIO drive
    input wire logic [W-1:0] gpio_oe, // GPIO enable
    input wire logic [W-1:0] pad_in, // Level seen on pad
    output logic [W-1:0] pad_out, // Pad drive value
    output logic [W-1:0] pad_oe, // Pad drive enable
    output logic [W-1:0] prim_in, // Pad level to primary function
    output logic [W-1:0] audio_in, // Pad level to audio port
    output logic [W-1:0] gpio_in // Pad level to GPIO
);
    always_comb
    begin
        pad_out = '0;
        pad_oe = '0;
        prim_in = '0;
        audio_in = '0;
        gpio_in = '0;
        // Only the single owner sees and drives the pad
        case (sel)
            spfs_pkg::SPFS_OWN_PRIMARY:
            begin
                pad_out = prim_out;
                pad_oe = prim_oe;
                prim_in = pad_in;
            end
            spfs_pkg::SPFS_OWN_AUDIO:
            begin
                pad_out = audio_out;
                pad_oe = audio_oe;
                audio_in = pad_in;
            end
            spfs_pkg::SPFS_OWN_GPIO:
            begin
                pad_out = gpio_out;
                pad_oe = gpio_oe;
                gpio_in = pad_in;
            end
            default:
            begin
                pad_out = '0;
            end
        endcase
    end
endmodule : spfs_pad_cell
`default_nettype wire

// ### spfs_shared_pin_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "spfs_cfg.svh"
module spfs_shared_pin_select
(
    input wire logic aclk, // Device clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read valid
    input wire logic s_axi_rready, // Read ready
    input wire logic host_port_enable_strap, // Enable strap level, high disables host
    input wire logic host_data5_width_strap, // Width strap level, high selects wide
    input wire logic [1:0] clkpad_in, // Clock pads in: 0 quarter, 1 sixth
    output logic [1:0] clkpad_out, // Clock pads drive
    output logic [1:0] clkpad_oe, // Clock pads enable
    input wire logic [5:0] ctlpad_in, // Host control pads in
    output logic [5:0] ctlpad_out, // Host control pads drive
    output logic [5:0] ctlpad_oe, // Host control pads enable
    input wire logic [31:0] datpad_in, // Host data pads in
    output logic [31:0] datpad_out, // Host data pads drive
    output logic [31:0] datpad_oe, // Host data pads enable
    input wire logic [5:0] host_ctrl_out, // Host port control drive
    input wire logic [5:0] host_ctrl_oe, // Host port control enable
    output logic [5:0] host_ctrl_in, // Host port control in
    input wire logic [31:0] host_data_out, // Host port data drive
    input wire logic [31:0] host_data_oe, // Host port data enable
    output logic [31:0] host_data_in, // Host port data in
    output logic host_port_enabled, // Host port owns its pads
    output logic host_port_wide_mode, // Host port is 32 bits wide
    input wire logic [15:0] audio1_data_out, // Audio port serial pins drive
    output logic [15:0] audio1_data_in, // Audio port serial pins in
    input wire logic audio1_receive_frame_sync_out, // Audio receive sync drive
    output logic audio1_receive_frame_sync_in, // Audio receive sync in
    input wire logic audio1_receive_clock_out, // Audio receive clock drive
    output logic audio1_receive_clock_in, // Audio receive clock in
    output logic audio_port1_enabled // Audio port owns some pads
);
    spfs_pkg::spfs_strap_t strap_r;
    spfs_pkg::spfs_strap_st_t strap_st_r;
    logic host_dis;
    logic wide;
    logic [15:0] gpio_en_r;
    logic [15:0] gpio_dir_r;
    logic [15:0] gpio_out_r;
    logic [15:0] gpio_in_r;
    logic [15:0] gpio_pad_in;
    logic [1:0] afc_r;
    logic [17:0] a1dir_r;
    logic [2:0] q_cnt_r;
    logic [2:0] s_cnt_r;
    logic [1:0] clk_r;
    logic [5:0] ctl_audio_in;
    logic aw_hold_r;
    logic w_hold_r;
    spfs_pkg::spfs_wr_t wr_r;
    logic do_wr;
    logic [31:0] rd_word;
    logic rd_err;
    logic wr_err;
    logic [31:0] wr_cur;
    logic [31:0] wr_new;

    function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (st[i])
            begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction : apply_strb

    // Straps caught on the first edge after release, then frozen
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            strap_st_r <= spfs_pkg::SPFS_ST_WAIT;
            strap_r <= {`SPFS_STRAP_DIS_RST, `SPFS_STRAP_HD5_RST};
        end
        else
        begin
            case (strap_st_r)
                spfs_pkg::SPFS_ST_WAIT:
                begin
                    strap_r.host_dis <= host_port_enable_strap;
                    strap_r.hd5_wide <= host_data5_width_strap;
                    strap_st_r <= spfs_pkg::SPFS_ST_HELD;
                end
                spfs_pkg::SPFS_ST_HELD:
                begin
                    strap_st_r <= spfs_pkg::SPFS_ST_HELD;
                end
                default:
                begin
                    strap_st_r <= spfs_pkg::SPFS_ST_WAIT;
                end
            endcase
        end
    end

    assign host_dis = strap_r.host_dis;
    assign wide = !strap_r.host_dis && strap_r.hd5_wide;
    assign host_port_enabled = !host_dis;
    assign host_port_wide_mode = wide;
    assign audio_port1_enabled = !wide;

    // Divided clock outputs, toggled every half period
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q_cnt_r <= 3'h0;
            s_cnt_r <= 3'h0;
            clk_r <= 2'h0;
        end
        else
        begin
            q_cnt_r <= (q_cnt_r == `SPFS_QUARTER_HALF - 3'h1) ? 3'h0 : q_cnt_r + 3'h1;
            s_cnt_r <= (s_cnt_r == `SPFS_SIXTH_HALF - 3'h1) ? 3'h0 : s_cnt_r + 3'h1;
            clk_r[0] <= (q_cnt_r == `SPFS_QUARTER_HALF - 3'h1) ? !clk_r[0] : clk_r[0];
            clk_r[1] <= (s_cnt_r == `SPFS_SIXTH_HALF - 3'h1) ? !clk_r[1] : clk_r[1];
        end
    end

    genvar g;
    for (g = 0; g < 2; g++)
    begin : g_clk
        spfs_pkg::spfs_owner_t own;
        assign own = gpio_en_r[g + 1] ? spfs_pkg::SPFS_OWN_GPIO : spfs_pkg::SPFS_OWN_PRIMARY;
        spfs_pad_cell #(.W(1)) u_cell
        (
            .sel(own),
            .prim_out(clk_r[g]),
            .prim_oe(1'b1),
            .audio_out(1'b0),
            .audio_oe(1'b0),
            .gpio_out(gpio_out_r[g + 1]),
            .gpio_oe(gpio_dir_r[g + 1]),
            .pad_in(clkpad_in[g]),
            .pad_out(clkpad_out[g]),
            .pad_oe(clkpad_oe[g]),
            .prim_in(),
            .audio_in(),
            .gpio_in(gpio_pad_in[g + 1])
        );
    end

    for (g = 0; g < 6; g++)
    begin : g_ctl
        spfs_pkg::spfs_owner_t own;
        logic hit;
        assign hit = (afc_r == 2'(g % 3));
        assign own = !host_dis ? spfs_pkg::SPFS_OWN_PRIMARY
            : (hit ? spfs_pkg::SPFS_OWN_AUDIO : spfs_pkg::SPFS_OWN_NONE);
        spfs_pad_cell #(.W(1)) u_cell
        (
            .sel(own),
            .prim_out(host_ctrl_out[g]),
            .prim_oe(host_ctrl_oe[g]),
            .audio_out(g < 3 ? audio1_receive_frame_sync_out : audio1_receive_clock_out),
            .audio_oe(g < 3 ? a1dir_r[`SPFS_A1_FS_BIT] : a1dir_r[`SPFS_A1_CLK_BIT]),
            .gpio_out(1'b0),
            .gpio_oe(1'b0),
            .pad_in(ctlpad_in[g]),
            .pad_out(ctlpad_out[g]),
            .pad_oe(ctlpad_oe[g]),
            .prim_in(host_ctrl_in[g]),
            .audio_in(ctl_audio_in[g]),
            .gpio_in()
        );
    end

    // Only the selected pad pair passes audio, so OR recovers it
    assign audio1_receive_frame_sync_in = |ctl_audio_in[2:0];
    assign audio1_receive_clock_in = |ctl_audio_in[5:3];

    spfs_pad_cell #(.W(16)) u_upper
    (
        .sel(wide ? spfs_pkg::SPFS_OWN_PRIMARY : spfs_pkg::SPFS_OWN_AUDIO),
        .prim_out(host_data_out[31:16]),
        .prim_oe(host_data_oe[31:16]),
        .audio_out(audio1_data_out),
        .audio_oe(a1dir_r[15:0]),
        .gpio_out(16'h0000),
        .gpio_oe(16'h0000),
        .pad_in(datpad_in[31:16]),
        .pad_out(datpad_out[31:16]),
        .pad_oe(datpad_oe[31:16]),
        .prim_in(host_data_in[31:16]),
        .audio_in(audio1_data_in),
        .gpio_in()
    );

    for (g = `SPFS_GPIO_HI_LSB; g < 16; g++)
    begin : g_hi
        spfs_pkg::spfs_owner_t own;
        assign own = !host_dis ? spfs_pkg::SPFS_OWN_PRIMARY
            : (gpio_en_r[g] ? spfs_pkg::SPFS_OWN_GPIO : spfs_pkg::SPFS_OWN_NONE);
        spfs_pad_cell #(.W(1)) u_cell
        (
            .sel(own),
            .prim_out(host_data_out[g]),
            .prim_oe(host_data_oe[g]),
            .audio_out(1'b0),
            .audio_oe(1'b0),
            .gpio_out(gpio_out_r[g]),
            .gpio_oe(gpio_dir_r[g]),
            .pad_in(datpad_in[g]),
            .pad_out(datpad_out[g]),
            .pad_oe(datpad_oe[g]),
            .prim_in(host_data_in[g]),
            .audio_in(),
            .gpio_in(gpio_pad_in[g])
        );
    end

    spfs_pad_cell #(.W(9)) u_lower
    (
        .sel(host_dis ? spfs_pkg::SPFS_OWN_NONE : spfs_pkg::SPFS_OWN_PRIMARY),
        .prim_out(host_data_out[8:0]),
        .prim_oe(host_data_oe[8:0]),
        .audio_out(9'h000),
        .audio_oe(9'h000),
        .gpio_out(9'h000),
        .gpio_oe(9'h000),
        .pad_in(datpad_in[8:0]),
        .pad_out(datpad_out[8:0]),
        .pad_oe(datpad_oe[8:0]),
        .prim_in(host_data_in[8:0]),
        .audio_in(),
        .gpio_in()
    );

    assign gpio_pad_in[0] = 1'b0;
    assign gpio_pad_in[8:3] = 6'h00;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gpio_in_r <= 16'h0000;
        end
        else
        begin
            gpio_in_r <= gpio_pad_in;
        end
    end

    // Write channel: address and data held independently, then committed together
    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
    assign do_wr = aw_hold_r && w_hold_r && !s_axi_bvalid;

    always_comb
    begin
        wr_err = 1'b0;
        wr_cur = 32'h00000000;
        case ({wr_r.addr[7:2], 2'b00})
            `SPFS_OFF_GPIO_EN: wr_cur = {16'h0000, gpio_en_r};
            `SPFS_OFF_GPIO_DIR: wr_cur = {16'h0000, gpio_dir_r};
            `SPFS_OFF_GPIO_OUT: wr_cur = {16'h0000, gpio_out_r};
            `SPFS_OFF_PERIPHERAL_CONFIG_REG: wr_cur = {30'h00000000, afc_r};
            `SPFS_OFF_A1DIR: wr_cur = {14'h0000, a1dir_r};
            `SPFS_OFF_GPIO_IN, `SPFS_OFF_STATUS: wr_cur = 32'h00000000;
            default: wr_err = 1'b1;
        endcase
        // Byte strobes merge into the current value of the addressed register
        wr_new = apply_strb(wr_cur, wr_r.data, wr_r.strb);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            wr_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SPFS_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_r <= 1'b1;
                wr_r.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_r <= 1'b1;
                wr_r.data <= s_axi_wdata;
                wr_r.strb <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_err ? `SPFS_RESP_SLVERR : `SPFS_RESP_OKAY;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Software-owned selection, direction and output bits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gpio_en_r <= `SPFS_GPIO_EN_RST;
            gpio_dir_r <= `SPFS_GPIO_DIR_RST;
            gpio_out_r <= `SPFS_GPIO_OUT_RST;
            afc_r <= `SPFS_AFC_RST;
            a1dir_r <= `SPFS_A1DIR_RST;
        end
        else if (do_wr)
        begin
            case ({wr_r.addr[7:2], 2'b00})
                `SPFS_OFF_GPIO_EN:
                    gpio_en_r <= wr_new[15:0] & `SPFS_GPIO_MASK;
                `SPFS_OFF_GPIO_DIR:
                    gpio_dir_r <= wr_new[15:0] & `SPFS_GPIO_MASK;
                `SPFS_OFF_GPIO_OUT:
                    gpio_out_r <= wr_new[15:0] & `SPFS_GPIO_MASK;
                `SPFS_OFF_PERIPHERAL_CONFIG_REG:
                    afc_r <= wr_new[1:0];
                `SPFS_OFF_A1DIR:
                    a1dir_r <= wr_new[17:0];
                default:
                    afc_r <= afc_r;
            endcase
        end
    end

    always_comb
    begin
        rd_word = 32'h00000000;
        rd_err = 1'b0;
        case ({s_axi_araddr[7:2], 2'b00})
            `SPFS_OFF_GPIO_EN: rd_word = {16'h0000, gpio_en_r};
            `SPFS_OFF_GPIO_DIR: rd_word = {16'h0000, gpio_dir_r};
            `SPFS_OFF_GPIO_OUT: rd_word = {16'h0000, gpio_out_r};
            `SPFS_OFF_GPIO_IN: rd_word = {16'h0000, gpio_in_r};
            `SPFS_OFF_PERIPHERAL_CONFIG_REG: rd_word = {30'h00000000, afc_r};
            `SPFS_OFF_A1DIR: rd_word = {14'h0000, a1dir_r};
            `SPFS_OFF_STATUS:
            begin
                rd_word[`SPFS_BIT_WIDTH] = wide;
                rd_word[`SPFS_BIT_HOSTDIS] = host_dis;
            end
            default: rd_err = 1'b1;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SPFS_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_err ? `SPFS_RESP_SLVERR : `SPFS_RESP_OKAY;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    property p_strap_hold;
        @(posedge aclk) disable iff (!aresetn)
        (strap_st_r == spfs_pkg::SPFS_ST_HELD) |=> $stable(strap_r);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap latch changed after capture");

    property p_strap_capture;
        @(posedge aclk) disable iff (!aresetn)
        (strap_st_r == spfs_pkg::SPFS_ST_WAIT) |=> strap_r.host_dis == $past(host_port_enable_strap);
    endproperty
    a_strap_capture: assert property (p_strap_capture) else $error("enable strap not captured");

    property p_one_owner;
        @(posedge aclk) disable iff (!aresetn)
        (wide |-> (datpad_oe[31:16] == host_data_oe[31:16]) && (audio1_data_in == 16'h0000))
            and (!wide |-> (host_data_in[31:16] == 16'h0000) && (datpad_oe[31:16] == a1dir_r[15:0]));
    endproperty
    a_one_owner: assert property (p_one_owner) else $error("two owners on a strap group");

    property p_clk_default;
        @(posedge aclk) disable iff (!aresetn)
        $past(!aresetn) |-> (gpio_en_r == 16'h0000) && (clkpad_oe == 2'h3) && (clkpad_out == clk_r);
    endproperty
    a_clk_default: assert property (p_clk_default) else $error("clock pads not clocks after reset");

    property p_gpio_enable;
        @(posedge aclk) disable iff (!aresetn)
        !gpio_en_r[1] |-> clkpad_oe[0] && (clkpad_out[0] == clk_r[0]);
    endproperty
    a_gpio_enable: assert property (p_gpio_enable) else $error("clock pad left clock function");

    property p_gpio_dir;
        @(posedge aclk) disable iff (!aresetn)
        gpio_en_r[2] |-> (clkpad_oe[1] == gpio_dir_r[2]) && (clkpad_out[1] == gpio_out_r[2]);
    endproperty
    a_gpio_dir: assert property (p_gpio_dir) else $error("gpio direction not applied");

    sequence s_released;
        $past(!aresetn) ##1 (strap_st_r == spfs_pkg::SPFS_ST_HELD);
    endsequence
    property p_default_wide;
        @(posedge aclk) disable iff (!aresetn)
        s_released ##0 (!strap_r.host_dis && strap_r.hd5_wide) |-> host_port_wide_mode && !audio_port1_enabled
            && (datpad_oe[31:16] == host_data_oe[31:16]);
    endproperty
    a_default_wide: assert property (p_default_wide) else $error("wide host not active");

    property p_disabled;
        @(posedge aclk) disable iff (!aresetn)
        host_dis |-> (datpad_oe[8:0] == 9'h000) && !host_port_enabled && (host_data_in[8:0] == 9'h000);
    endproperty
    a_disabled: assert property (p_disabled) else $error("host still drives when disabled");

    property p_narrow;
        @(posedge aclk) disable iff (!aresetn)
        (!strap_r.host_dis && !strap_r.hd5_wide) |-> (datpad_out[31:16] == audio1_data_out)
            && (datpad_oe[31:16] == a1dir_r[15:0]) && host_port_enabled;
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow mode upper pads not audio");

    property p_afc_pick;
        @(posedge aclk) disable iff (!aresetn)
        (host_dis && afc_r == 2'h1) |-> (ctlpad_out[1] == audio1_receive_frame_sync_out)
            && (ctlpad_out[4] == audio1_receive_clock_out) && (ctlpad_oe[0] == 1'b0) && (ctlpad_oe[5] == 1'b0);
    endproperty
    a_afc_pick: assert property (p_afc_pick) else $error("wrong pads carry audio receive pair");

    property p_hi_host;
        @(posedge aclk) disable iff (!aresetn)
        !host_dis |-> (datpad_oe[15:9] == host_data_oe[15:9]) && (gpio_pad_in[15:9] == 7'h00);
    endproperty
    a_hi_host: assert property (p_hi_host) else $error("upper host data pads left host");

    property p_status;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `SPFS_OFF_STATUS) |=>
            s_axi_rvalid && (s_axi_rdata[`SPFS_BIT_WIDTH] == $past(wide))
            && (s_axi_rdata[`SPFS_BIT_HOSTDIS] == $past(host_dis));
    endproperty
    a_status: assert property (p_status) else $error("status bits wrong");
endmodule : spfs_shared_pin_select
`default_nettype wire

// ### spfs_strap_model.sv
`timescale 1ns/1ps
`default_nettype none
module spfs_strap_model
(
    input wire logic aclk, // Device clock
    input wire logic dis_req, // Board wants host port off
    input wire logic wide_req, // Board wants wide host port
    output logic host_port_enable_strap, // Strap level seen by device
    output logic host_data5_width_strap // Width strap level
);
    always_ff @(posedge aclk)
    begin
        host_port_enable_strap <= dis_req;
        host_data5_width_strap <= wide_req;
    end
endmodule : spfs_strap_model
`default_nettype wire

// ### test_shared_pin_function_select.sv
`timescale 1ns/1ps
`default_nettype none
module test_shared_pin_function_select;
    logic aclk, aresetn, awv, wv, bv, br, arv, rv, rr, dis_req, wide_req, he, hw, ff, fc, awr, wr_r, arr;
    logic [7:0] awa, ara;
    logic [3:0] wst;
    logic [1:0] bresp, rresp, ci, co, coe, afc;
    logic [5:0] cti, cto, ctoe, hco, hcoe, hci;
    logic [31:0] wd, rdat, di, dout, doe, hdo, hdoe, hdi, x, d, q;
    logic [15:0] ado, adi;
    logic hen, hwide, aen, fsi, cki;
    int errors, n_tests, cyc;
    spfs_strap_model i_spfs_strap_model (.aclk(aclk), .dis_req(dis_req), .wide_req(wide_req),
        .host_port_enable_strap(he), .host_data5_width_strap(hw));
    spfs_shared_pin_select i_spfs_shared_pin_select (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wst), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .host_port_enable_strap(he), .host_data5_width_strap(hw), .clkpad_in(ci),
        .clkpad_out(co), .clkpad_oe(coe), .ctlpad_in(cti), .ctlpad_out(cto), .ctlpad_oe(ctoe), .datpad_in(di),
        .datpad_out(dout), .datpad_oe(doe), .host_ctrl_out(hco), .host_ctrl_oe(hcoe), .host_ctrl_in(hci),
        .host_data_out(hdo), .host_data_oe(hdoe), .host_data_in(hdi), .host_port_enabled(hen),
        .host_port_wide_mode(hwide), .audio1_data_out(ado), .audio1_data_in(adi),
        .audio1_receive_frame_sync_out(ff), .audio1_receive_frame_sync_in(fsi),
        .audio1_receive_clock_out(fc), .audio1_receive_clock_in(cki), .audio_port1_enabled(aen));
    function automatic logic [31:0] rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : rnd
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic conclude();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic pa, pw;
        pa = 1;
        pw = 1;
        awa <= a;
        wd <= v;
        awv <= 1;
        wv <= 1;
        br <= 1;
        while (pa || pw)
        begin
            @(posedge aclk);
            if (pa && awr)
            begin
                pa = 0;
                awv <= 0;
            end
            if (pw && wr_r)
            begin
                pw = 0;
                wv <= 0;
            end
        end
        do @(posedge aclk); while (bv !== 1'b1);
        q = {30'h0, bresp};
    endtask : wr
    task automatic rd(input logic [7:0] a);
        ara <= a;
        arv <= 1;
        rr <= 1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 0;
        do @(posedge aclk); while (rv !== 1'b1);
        q = rdat;
        afc = rresp;
    endtask : rd
    task automatic rst(input logic s_dis, input logic s_wide);
        dis_req <= s_dis;
        wide_req <= s_wide;
        aresetn <= 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        repeat (3) @(posedge aclk);
    endtask : rst
    initial
    begin
        aclk = 0;
        forever #10 aclk = ~aclk;
    end
    // Peripheral-side and pad inputs toggle at random every cycle
    initial {di, hdo, hdoe, cti, hco, hcoe, ci, ado, ff, fc} = '0;
    always @(posedge aclk)
    begin
        {di, hdo, hdoe, cti, hco, hcoe, ci, ado, ff, fc} <= 134'({rnd(), rnd(), rnd(), rnd(), rnd()} >> 26);
        cyc++;
        if (cyc > 5000)
        begin
            errors++;
            conclude();
        end
    end
    initial
    begin
        x = 65148;
        {aresetn, awv, wv, br, arv, rr, dis_req, wide_req, awa, ara, wd} = '0;
        wst = 4'hF;
        rst(1'b0, 1'b1);
        rd(8'h18);
        chk("status", 32'h0000_0400, q);
        rd(8'h00);
        chk("gpio_en", 32'h0, q);
        @(negedge aclk);
        chk("clk_oe", 32'h3, coe);
        chk("dat_oe", hdoe, doe);
        chk("modes", 32'h6, {hen, hwide, aen});
        q = {30'h0, co};
        d = 0;
        repeat (12)
        begin
            @(negedge aclk);
            d = d + {q[1] ^ co[1], 15'h0, q[0] ^ co[0]};
            q = {30'h0, co};
        end
        chk("clk_rates", 32'h0004_0006, d);
        dis_req <= 1;
        wide_req <= 0;
        repeat (4) @(posedge aclk);
        rd(8'h18);
        chk("held", 32'h0000_0400, q);
        rst(1'b0, 1'b0);
        rd(8'h18);
        chk("narrow", 32'h0, q);
        d = rnd();
        wr(8'h14, d);
        @(negedge aclk);
        chk("aud_oe", {d[15:0], hdoe[15:0]}, doe);
        chk("aud_out", {ado, hdo[15:0]}, dout);
        chk("aud_in", {di[31:16], 16'h0000}, {adi, hdi[31:16]});
        rst(1'b1, 1'b1);
        rd(8'h18);
        chk("dis", 32'h0000_0100, q);
        d = rnd();
        wr(8'h04, d);
        @(negedge aclk);
        chk("clk_keep", 32'h3, coe);
        wr(8'h00, 32'h0000_FE06);
        @(negedge aclk);
        chk("gpio_oe", {d[15:9], d[2:1]}, {doe[15:9], coe});
        wr(8'h08, d);
        @(negedge aclk);
        chk("gpio_out", {d[15:9], d[2:1]}, {dout[15:9], co});
        for (int k = 0; k < 4; k++)
        begin
            rst(1'b1, 1'b1);
            wr(8'h14, 32'h0003_0000);
            wr(8'h10, k);
            @(negedge aclk);
            chk("ctl_oe", (k < 3) ? (32'h9 << k) : 32'h0, ctoe);
            chk("ctl_in", (k < 3) ? {cti[k + 3], cti[k]} : 2'b00, {cki, fsi});
        end
        rd(8'h40);
        chk("unmapped", 32'h2, afc);
        wr(8'h40, d);
        chk("wr_unmapped", 32'h2, q);
        conclude();
    end
endmodule : test_shared_pin_function_select
`default_nettype wire
